//--- src/pirex_exec.sv
/*
  Execution logic for the global pulse, calibration injection and
  register write commands.
  Assumes decoded commands arrive from logic on clk, while the bunch
  clock, the 160 MHz clock and the die identity straps arrive as pins.
*/
`timescale 1ns/1ps

module pirex_exec #(
  parameter logic [8:0] REG_LAST  = 9'h0ff,
  parameter int         FINE_W    = 4
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset,
  // Pins from outside the clock domain
  input  wire logic                    bx_clk,
  input  wire logic                    fast_clk,
  input  wire logic [2:0]              die_selector,
  // Decoded command from the decoder
  input  wire logic                    cmd_valid,
  input  wire pirex_pkg::pirex_cmd_t   cmd,
  // Configuration
  input  wire logic [FINE_W-1:0]       fine_delay,
  // Outputs
  output logic                         global_pulse,
  output logic                         cal_edge,
  output logic                         cal_edge_matrix,
  output logic                         cal_aux,
  output pirex_pkg::pirex_wr_t         wr_port,
  output logic                         wr_warning
);
  import pirex_pkg::*;

  typedef enum {EDGE_IDLE, EDGE_DELAY, EDGE_WIDTH} pirex_edge_t;

  function automatic logic [GP_CNT_W-1:0] gp_len(input logic [3:0] v);
    if (v > GP_MAX_EXP) begin
      gp_len = GP_CNT_W'(1) << GP_MAX_EXP;
    end else begin
      gp_len = GP_CNT_W'(1) << v;
    end
  endfunction

  // Rounds a count of fine steps up to whole clk cycles
  function automatic logic [3:0] fine_tap(input logic [FINE_W-1:0] f);
    int t;
    t = (int'(f) * FINE_STEP_HPS + CLK_PERIOD_HPS - 1) / CLK_PERIOD_HPS;
    if (t > FINE_TAPS - 1) begin
      t = FINE_TAPS - 1;
    end
    fine_tap = t[3:0];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // A level counts once stages two and three agree; stage one feeds
  // only stage two.
  logic [2:0] bx_s, fast_s;
  logic [2:0] die_s1, die_s2, die_s3;
  logic       bx_f, fast_f;
  logic [2:0] die_f;
  logic       next_bx_f, next_fast_f;
  logic [2:0] next_die_f;
  logic       bx_rise, fast_rise;

  always_comb begin
    next_bx_f   = (bx_s[1] == bx_s[2]) ? bx_s[2] : bx_f;
    next_fast_f = (fast_s[1] == fast_s[2]) ? fast_s[2] : fast_f;
    next_die_f  = (die_s2 == die_s3) ? die_s3 : die_f;
    bx_rise     = next_bx_f & ~bx_f;
    fast_rise   = next_fast_f & ~fast_f;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bx_s   <= 3'h0;
      fast_s <= 3'h0;
      die_s1 <= 3'h0;
      die_s2 <= 3'h0;
      die_s3 <= 3'h0;
      bx_f   <= 1'b0;
      fast_f <= 1'b0;
      die_f  <= 3'h0;
    end else begin
      bx_s   <= {bx_s[1:0], bx_clk};
      fast_s <= {fast_s[1:0], fast_clk};
      die_s1 <= die_selector;
      die_s2 <= die_s1;
      die_s3 <= die_s2;
      bx_f   <= next_bx_f;
      fast_f <= next_fast_f;
      die_f  <= next_die_f;
    end
  end

  // ----------------------------------------------------------------
  // Execution timing
  // ----------------------------------------------------------------
  // Commands are held for the fixed latency and released on the
  // next crossing edge; a later command simply replaces the held one.
  pirex_cmd_t pend, next_pend;
  logic       pend_valid, next_pend_valid;
  logic [3:0] lat_cnt, next_lat_cnt;
  logic       fire, selected;
  logic       exec_gp, exec_cal, exec_wr;

  always_comb begin
    next_pend       = pend;
    next_pend_valid = pend_valid;
    next_lat_cnt    = lat_cnt;
    fire            = pend_valid && (lat_cnt == 4'h0) && bx_rise;
    selected = pend.sel[SEL_BCAST_POS] || (pend.sel[2:0] == die_f);
    exec_gp  = fire && selected && (pend.kind == PIREX_CMD_GPULSE);
    exec_cal = fire && selected && (pend.kind == PIREX_CMD_CAL);
    exec_wr  = fire && selected && (pend.kind == PIREX_CMD_REGWR);
    if (cmd_valid) begin
      next_pend       = cmd;
      next_pend_valid = 1'b1;
      next_lat_cnt    = 4'(EXEC_DELAY_CYC - 1);
    end else if (fire) begin
      next_pend_valid = 1'b0;
    end else if (pend_valid && lat_cnt != 4'h0) begin
      next_lat_cnt = lat_cnt - 4'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend       <= '0;
      pend_valid <= 1'b0;
      lat_cnt    <= 4'h0;
    end else begin
      pend       <= next_pend;
      pend_valid <= next_pend_valid;
      lat_cnt    <= next_lat_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Global pulse
  // ----------------------------------------------------------------
  logic [GP_CNT_W-1:0] gp_cnt, next_gp_cnt;
  logic                next_global_pulse;

  always_comb begin
    next_gp_cnt       = gp_cnt;
    next_global_pulse = global_pulse;
    if (exec_gp) begin
      next_gp_cnt       = gp_len(pend.gp_value);
      next_global_pulse = 1'b1;
    end else if (global_pulse && bx_rise) begin
      // Counts crossing edges after the one that raised the pulse
      if (gp_cnt == GP_CNT_W'(1)) begin
        next_global_pulse = 1'b0;
        next_gp_cnt       = '0;
      end else begin
        next_gp_cnt = gp_cnt - GP_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gp_cnt       <= '0;
      global_pulse <= STROBE_RST;
    end else begin
      gp_cnt       <= next_gp_cnt;
      global_pulse <= next_global_pulse;
    end
  end

  // ----------------------------------------------------------------
  // Primary injection strobe
  // ----------------------------------------------------------------
  // The mode bit sets the strobe shape: a pulse of the set width, or
  // a step left high; the matrix decides how to use it.
  pirex_edge_t          edge_st, next_edge_st;
  logic [CAL_DLY_W-1:0] dly_cnt, next_dly_cnt;
  logic [CAL_WID_W-1:0] wid_cnt, next_wid_cnt;
  logic                 pulse_mode, next_pulse_mode;
  logic                 next_cal_edge;
  logic                 c_mode;
  logic [CAL_DLY_W-1:0] c_dly;
  logic [CAL_WID_W-1:0] c_wid;

  always_comb begin
    c_mode = pend.cal_data[CAL_MODE_POS];
    c_dly  = pend.cal_data[CAL_DLY_LSB +: CAL_DLY_W];
    c_wid  = pend.cal_data[CAL_WID_LSB +: CAL_WID_W];
    next_edge_st    = edge_st;
    next_dly_cnt    = dly_cnt;
    next_wid_cnt    = wid_cnt;
    next_pulse_mode = pulse_mode;
    next_cal_edge   = cal_edge;
    // Zero width, or a strobe already high, leaves the edge alone
    if (exec_cal && c_wid != '0 && !cal_edge) begin
      next_edge_st    = EDGE_DELAY;
      next_dly_cnt    = c_dly;
      next_wid_cnt    = c_wid;
      next_pulse_mode = c_mode;
    end else begin
      case (edge_st)
        EDGE_DELAY: begin
          if (dly_cnt == '0) begin
            if (fast_rise) begin
              next_cal_edge = 1'b1;
              next_edge_st  = c_pulse_next(pulse_mode);
            end
          end else if (bx_rise) begin
            next_dly_cnt = dly_cnt - 1'b1;
          end
        end
        EDGE_WIDTH: begin
          if (fast_rise) begin
            if (wid_cnt == CAL_WID_W'(1)) begin
              next_cal_edge = 1'b0;
              next_edge_st  = EDGE_IDLE;
            end else begin
              next_wid_cnt = wid_cnt - 1'b1;
            end
          end
        end
        EDGE_IDLE: begin
          next_edge_st = EDGE_IDLE;
        end
        default: begin
          next_edge_st = EDGE_IDLE;
        end
      endcase
    end
  end

  // Step mode ends with the strobe left high
  function automatic pirex_edge_t c_pulse_next(input logic pm);
    c_pulse_next = pm ? EDGE_WIDTH : EDGE_IDLE;
  endfunction

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      edge_st    <= EDGE_IDLE;
      dly_cnt    <= '0;
      wid_cnt    <= '0;
      pulse_mode <= 1'b0;
      cal_edge   <= STROBE_RST;
    end else begin
      edge_st    <= next_edge_st;
      dly_cnt    <= next_dly_cnt;
      wid_cnt    <= next_wid_cnt;
      pulse_mode <= next_pulse_mode;
      cal_edge   <= next_cal_edge;
    end
  end

  // ----------------------------------------------------------------
  // Fine delay toward the matrix
  // ----------------------------------------------------------------
  // Resolution is limited to whole clk cycles; the summed 640 MHz steps
  // are rounded up, so the delay never falls short of the setting.
  logic [FINE_TAPS-1:0] fine_line, next_fine_line;
  logic                 next_cal_edge_matrix;

  always_comb begin
    next_fine_line       = {fine_line[FINE_TAPS-2:0], cal_edge};
    next_cal_edge_matrix = next_fine_line[fine_tap(fine_delay)];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fine_line       <= '0;
      cal_edge_matrix <= STROBE_RST;
    end else begin
      fine_line       <= next_fine_line;
      cal_edge_matrix <= next_cal_edge_matrix;
    end
  end

  // ----------------------------------------------------------------
  // Auxiliary level
  // ----------------------------------------------------------------
  logic                  aux_busy, next_aux_busy;
  logic [CAL_AUXD_W-1:0] aux_cnt, next_aux_cnt;
  logic                  aux_val, next_aux_val;
  logic                  next_cal_aux;

  always_comb begin
    next_aux_busy = aux_busy;
    next_aux_cnt  = aux_cnt;
    next_aux_val  = aux_val;
    next_cal_aux  = cal_aux;
    if (exec_cal) begin
      next_aux_busy = 1'b1;
      next_aux_cnt  = pend.cal_data[CAL_AUXD_LSB +: CAL_AUXD_W];
      next_aux_val  = pend.cal_data[CAL_AUXV_POS];
    end else if (aux_busy && fast_rise) begin
      if (aux_cnt == '0) begin
        next_cal_aux  = aux_val;
        next_aux_busy = 1'b0;
      end else begin
        next_aux_cnt = aux_cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aux_busy <= 1'b0;
      aux_cnt  <= '0;
      aux_val  <= 1'b0;
      cal_aux  <= STROBE_RST;
    end else begin
      aux_busy <= next_aux_busy;
      aux_cnt  <= next_aux_cnt;
      aux_val  <= next_aux_val;
      cal_aux  <= next_cal_aux;
    end
  end

  // ----------------------------------------------------------------
  // Register write sequencer
  // ----------------------------------------------------------------
  // Writes go only to the register file port; nothing here reaches
  // the outgoing data path.
  logic [2:0]  beats, next_beats;
  logic [95:0] wr_shift, next_wr_shift;
  logic [8:0]  wr_addr, next_wr_addr;
  pirex_wr_t   next_wr_port;
  logic        next_wr_warning;
  logic        unused;

  always_comb begin
    next_beats      = beats;
    next_wr_shift   = wr_shift;
    next_wr_addr    = wr_addr;
    next_wr_port    = '0;
    next_wr_warning = 1'b0;
    unused          = pend.wr_addr > REG_LAST;
    if (exec_wr) begin
      if (unused) begin
        next_wr_warning = 1'b1;
        next_beats      = 3'h0;
      end else begin
        next_beats    = pend.wr_wide ? BEATS_WIDE : BEATS_NARROW;
        next_wr_addr  = pend.wr_addr;
        // A narrow write carries its word in the bottom lane; it moves to the top
        next_wr_shift = pend.wr_wide ? pend.wr_data :
                        {pend.wr_data[WR_WORD_W-1:0], 80'h0};
      end
    end else if (beats != 3'h0) begin
      next_wr_port.addr     = wr_addr;
      next_wr_port.data     = wr_shift[95 -: WR_WORD_W];
      next_wr_port.pixel_en = (wr_addr == PIXEL_ADDR);
      next_wr_port.reg_en   = (wr_addr != PIXEL_ADDR);
      next_wr_shift         = {wr_shift[79:0], 16'h0000};
      next_beats            = beats - 3'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      beats      <= 3'h0;
      wr_shift   <= '0;
      wr_addr    <= 9'h000;
      wr_port    <= '0;
      wr_warning <= 1'b0;
    end else begin
      beats      <= next_beats;
      wr_shift   <= next_wr_shift;
      wr_addr    <= next_wr_addr;
      wr_port    <= next_wr_port;
      wr_warning <= next_wr_warning;
    end
  end

endmodule

//--- src/pirex_pkg.sv
/*
  Shared constants and carriers for the pulse, injection and register
  write execution block.
  Assumes a 250 MHz system clock and an upstream decoder that delivers
  one fully decoded command per valid pulse in the same clock domain.
*/
package pirex_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int EXEC_DELAY_NS   = 25;
  // Least time, so rounded up
  localparam int EXEC_DELAY_CYC  =
    (EXEC_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Fine step of 1.5625 ns held in half picoseconds to stay integer
  localparam int FINE_STEP_HPS   = 3125;
  localparam int CLK_PERIOD_HPS  = 2 * CLK_PERIOD_PS;
  localparam int FINE_TAPS       = 16;

  // ----------------------------------------------------------------
  // Global pulse
  // ----------------------------------------------------------------
  localparam logic [3:0] GP_MAX_EXP = 4'h9;
  localparam int         GP_CNT_W   = 10;

  // ----------------------------------------------------------------
  // Injection payload positions within the 16 data bits
  // ----------------------------------------------------------------
  localparam int CAL_MODE_POS   = 15;
  localparam int CAL_DLY_LSB    = 12;
  localparam int CAL_WID_LSB    = 6;
  localparam int CAL_AUXV_POS   = 5;
  localparam int CAL_AUXD_LSB   = 0;
  localparam int CAL_DLY_W      = 3;
  localparam int CAL_WID_W      = 6;
  localparam int CAL_AUXD_W     = 5;

  // ----------------------------------------------------------------
  // Selector field: broadcast on top, die identity below
  // ----------------------------------------------------------------
  localparam int SEL_BCAST_POS  = 3;

  // ----------------------------------------------------------------
  // Register write
  // ----------------------------------------------------------------
  localparam int         WR_WORD_W    = 16;
  localparam int         WR_WIDE_BEATS = 6;
  localparam logic [8:0] PIXEL_ADDR   = 9'h000;
  localparam logic [2:0] BEATS_NARROW = 3'h1;
  localparam logic [2:0] BEATS_WIDE   = 3'h6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic STROBE_RST = 1'b0;

  typedef enum logic [1:0] {
    PIREX_CMD_NONE,
    PIREX_CMD_GPULSE,
    PIREX_CMD_CAL,
    PIREX_CMD_REGWR
  } pirex_kind_t;

  typedef struct packed {
    pirex_kind_t  kind;
    logic [3:0]   sel;      // Broadcast bit and 3-bit die identity
    logic [3:0]   gp_value;
    logic [15:0]  cal_data;
    logic         wr_wide;
    logic [8:0]   wr_addr;
    logic [95:0]  wr_data;  // First word in the top bits
  } pirex_cmd_t;

  typedef struct packed {
    logic         reg_en;
    logic         pixel_en;
    logic [8:0]   addr;
    logic [15:0]  data;
  } pirex_wr_t;

endpackage

//--- verif/pirex_daq.sv
/*
  Controller model that hands decoded commands to pirex_exec.
  Assumes its tasks are called from one bench process.
*/
`timescale 1ns/1ps
module pirex_daq (
  // Clock
  input  wire logic       clk,
  // Command out
  output logic            cmd_valid,
  output pirex_pkg::pirex_cmd_t cmd
);
  import pirex_pkg::*;

  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end

  function automatic pirex_cmd_t base(pirex_kind_t k, logic [3:0] s);
    pirex_cmd_t c;
    c      = '1;
    c.kind = k;
    c.sel  = s;
    return c;
  endfunction

  task automatic send(input pirex_cmd_t c);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd       <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // Idle lines show the inverse so nothing stale looks valid
    cmd       <= ~c;
  endtask

  task automatic gp(input logic [3:0] s, input logic [3:0] v);
    pirex_cmd_t c;
    c          = base(PIREX_CMD_GPULSE, s);
    c.gp_value = v;
    send(c);
  endtask

  task automatic wr(input logic [3:0] s, input logic wide,
                    input logic [8:0] a, input logic [95:0] d);
    pirex_cmd_t c;
    c         = base(PIREX_CMD_REGWR, s);
    c.wr_wide = wide;
    c.wr_addr = a;
    c.wr_data = d;
    send(c);
  endtask

  task automatic cal(input logic [3:0] s, input logic md,
                     input logic [2:0] dl, input logic [5:0] w,
                     input logic av, input logic [4:0] ad);
    pirex_cmd_t c;
    c          = base(PIREX_CMD_CAL, s);
    c.cal_data = {md, dl, w, av, ad};
    send(c);
  endtask
endmodule

//--- verif/pirex_exec_sva.sv
/*
  Port checker for pirex_exec, bound to every instance.
  Assumes bench pins bx_clk and fast_clk hold each level over 10 clk.
*/
`timescale 1ns/1ps
module pirex_exec_sva #(
  parameter logic [8:0] REG_LAST = 9'h0ff,
  parameter int         FINE_W   = 4
) (
  // Clock, reset and pins
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic                  bx_clk,
  input wire logic                  fast_clk,
  input wire logic [2:0]            die_selector,
  // Command and setting
  input wire logic                  cmd_valid,
  input wire pirex_pkg::pirex_cmd_t cmd,
  input wire logic [FINE_W-1:0]     fine_delay,
  // Outputs under watch
  input wire logic                  global_pulse,
  input wire logic                  cal_edge,
  input wire logic                  cal_edge_matrix,
  input wire logic                  cal_aux,
  input wire pirex_pkg::pirex_wr_t  wr_port,
  input wire logic                  wr_warning
);
  import pirex_pkg::*;

  logic       wr;
  logic [7:0] hist;
  logic [2:0] beats;
  int         dly;

  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  assign wr  = wr_port.reg_en | wr_port.pixel_en;
  // Whole clock cycles, rounded up, as the strobe path rounds
  assign dly = 1 + (int'(fine_delay) * FINE_STEP_HPS
             + CLK_PERIOD_HPS - 1) / CLK_PERIOD_HPS;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hist  <= 8'h00;
      beats <= 3'h0;
    end else begin
      hist  <= {hist[6:0], cal_edge};
      beats <= wr ? beats + 3'h1 : 3'h0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Raw pin rose a few cycles ago, after the synchroniser delay
  sequence s_bx_new;
    bx_clk && !$past(bx_clk, 10);
  endsequence
  sequence s_fast_new;
    fast_clk && !$past(fast_clk, 10);
  endsequence

  a_pixel_addr: assert property (wr_port.pixel_en |->
    wr_port.addr == PIXEL_ADDR && !wr_port.reg_en)
    else $error("pixel write off address zero");
  a_reg_range: assert property (wr_port.reg_en |->
    wr_port.addr != PIXEL_ADDR && wr_port.addr <= REG_LAST)
    else $error("register write to unused address");
  a_warn_nowrite: assert property (wr_warning |->
    !wr ##1 (!wr && !wr_warning))
    else $error("warning came with a write");
  a_beat_addr: assert property (wr && $past(wr) |->
    $stable(wr_port.addr))
    else $error("address moved within a burst");
  a_beat_count: assert property (wr |-> beats < 3'h6)
    else $error("more than six write beats");
  a_exec_wait: assert property (cmd_valid &&
    cmd.kind == PIREX_CMD_REGWR |=> !(wr || wr_warning) [*7])
    else $error("write before execution latency");
  a_gp_on_bx: assert property ($changed(global_pulse) |-> s_bx_new)
    else $error("pulse edge off the crossing clock");
  a_wr_on_bx: assert property ($rose(wr) |-> s_bx_new)
    else $error("write start off the crossing clock");
  a_edge_fast: assert property ($changed(cal_edge) |-> s_fast_new)
    else $error("strobe edge off the fast clock");
  a_aux_fast: assert property ($changed(cal_aux) |-> s_fast_new)
    else $error("aux edge off the fast clock");
  a_fine_delay: assert property (cal_edge_matrix == hist[dly-1])
    else $error("matrix strobe delay wrong");
endmodule

bind pirex_exec pirex_exec_sva #(
  .REG_LAST (REG_LAST),
  .FINE_W   (FINE_W)
) u_sva (
  .clk, .reset, .bx_clk, .fast_clk, .die_selector, .cmd_valid, .cmd,
  .fine_delay, .global_pulse, .cal_edge, .cal_edge_matrix, .cal_aux,
  .wr_port, .wr_warning
);

//--- verif/pirex_exec_tb.sv
/*
  Self-checking bench for pirex_exec with a controller model.
  Assumes the bench pins run slow enough for the synchronisers.
*/
`timescale 1ns/1ps
module pirex_exec_tb;
  import pirex_pkg::*;

  localparam logic [2:0] ID   = 3'h5;
  localparam logic [8:0] LAST = 9'h0ff;

  logic        clk;
  logic        reset;
  logic        bx_clk;
  logic        fast_clk;
  logic [2:0]  die_selector;
  logic [3:0]  fine_delay;
  logic        cmd_valid;
  pirex_cmd_t  cmd;
  logic        global_pulse;
  logic        cal_edge;
  logic        cal_edge_matrix;
  logic        cal_aux;
  pirex_wr_t   wr_port;
  logic        wr_warning;
  int          err_total = 0;
  int          tests_run = 0;
  int          q_gp[$];
  int          q_cal[$];
  logic [27:0] q_wr[$];
  int          n_gp = 0;
  int          n_cal = 0;
  logic        bx_q = 1'b0;
  logic        fast_q = 1'b0;
  logic        gp_q = 1'b0;
  logic        ce_q = 1'b0;

  pirex_exec #(.REG_LAST(LAST), .FINE_W(4)) DUT (
    .clk, .reset, .bx_clk, .fast_clk, .die_selector, .cmd_valid, .cmd,
    .fine_delay, .global_pulse, .cal_edge, .cal_edge_matrix, .cal_aux,
    .wr_port, .wr_warning
  );
  pirex_daq DAQ (.clk, .cmd_valid, .cmd);

  // ------------------------------------------------------------
  // Clocks; fast_clk drifts against clk, while bx_clk keeps one fixed phase
  // ------------------------------------------------------------
  always #2 clk = ~clk;
  initial begin
    bx_clk = 1'b0;
    #1.3 forever #50 bx_clk = ~bx_clk;
  end
  initial begin
    fast_clk = 1'b0;
    #0.7 forever #62.5 fast_clk = ~fast_clk;
  end

  task automatic fail(input string m);
    err_total++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic cmp_len(input int got, input int exp);
    tests_run++;
    if (got != exp) fail($sformatf("length %0d not %0d", got, exp));
  endtask
  task automatic cmp_bit(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp) fail(m);
  endtask
  task automatic cmp_wr(input logic [27:0] got, input logic [27:0] exp);
    tests_run++;
    if (got !== exp) fail($sformatf("write %h not %h", got, exp));
  endtask

  // ------------------------------------------------------------
  // Monitor: lengths counted in raw pin rises while high
  // ------------------------------------------------------------
  always @(negedge clk) begin
    if (!reset) begin
      if (bx_clk && !bx_q && global_pulse) n_gp++;
      if (fast_clk && !fast_q && cal_edge) n_cal++;
      if (gp_q && !global_pulse) begin
        if (q_gp.size() == 0) fail("unexpected pulse");
        else cmp_len(n_gp, q_gp.pop_front());
      end
      if (ce_q && !cal_edge) begin
        if (q_cal.size() == 0) fail("unexpected strobe fall");
        else cmp_len(n_cal, q_cal.pop_front());
      end
      if (wr_port.reg_en | wr_port.pixel_en | wr_warning) begin
        if (q_wr.size() == 0) fail("unexpected write");
        else cmp_wr({wr_warning, wr_warning ? 27'h0 : wr_port},
                    q_wr.pop_front());
      end
    end
    if (!global_pulse) n_gp = 0;
    if (!cal_edge) n_cal = 0;
    {bx_q, fast_q, gp_q, ce_q} = {bx_clk, fast_clk, global_pulse, cal_edge};
  end

  task automatic wait_idle();
    int i;
    i = 0;
    while (q_gp.size() + q_cal.size() + q_wr.size() != 0 && i < 20000) begin
      @(negedge clk);
      i++;
    end
    if (i == 20000) fail("result never came");
    repeat (50) @(negedge clk);
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    fail("watchdog expired");
    results();
  end

  initial begin
    int          v;
    logic [3:0]  e;
    logic [5:0]  w;
    logic [8:0]  a;
    logic [95:0] d;
    clk          = 1'b0;
    reset        = 1'b1;
    die_selector = ID;
    void'($urandom(32'hf539));
    fine_delay   = 4'($urandom_range(15));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (20) @(posedge clk);
    // Every value up to nine, then one clipped value
    for (v = 0; v <= 10; v++) begin
      e = (v < 10) ? v[3:0] : 4'(10 + $urandom_range(5));
      q_gp.push_back(e > 4'h9 ? 512 : 1 << e);
      DAQ.gp(v[0] ? {1'b1, ~ID} : {1'b0, ID}, e);
      wait_idle();
    end
    // Another die's write must leave every output alone; the pulse command before it is replaced unexecuted
    DAQ.gp({1'b0, ~ID}, 4'h3);
    DAQ.wr({1'b0, ~ID}, 1'b0, 9'h001, 96'h0);
    repeat (600) @(negedge clk);
    cmp_bit(global_pulse, 1'b0, "unselected pulse");
    $display("Test global pulse done");
    a = 9'(1 + $urandom_range(254));
    d = {$urandom, $urandom, $urandom};
    q_wr.push_back({3'b010, a, d[15:0]});
    DAQ.wr({1'b1, ~ID}, 1'b0, a, d);
    wait_idle();
    for (v = 5; v >= 0; v--) begin
      q_wr.push_back({3'b001, PIXEL_ADDR, d[v*16 +: 16]});
    end
    DAQ.wr({1'b0, ID}, 1'b1, PIXEL_ADDR, d);
    wait_idle();
    q_wr.push_back({1'b1, 27'h0});
    DAQ.wr({1'b0, ID}, 1'b0, 9'h1ff, d);
    wait_idle();
    $display("Test register write done");
    DAQ.cal({1'b0, ID}, 1'b1, 3'h0, 6'h0, 1'b0, 5'h0);
    repeat (400) @(negedge clk);
    cmp_bit(cal_edge, 1'b0, "zero width moved strobe");
    for (v = 0; v < 2; v++) begin
      w = 6'(1 + $urandom_range(19));
      q_cal.push_back(int'(w));
      DAQ.cal({1'b1, ~ID}, 1'b1, 3'($urandom_range(7)), w, ~v[0],
              5'($urandom));
      wait_idle();
      repeat (1200) @(negedge clk);
      cmp_bit(cal_aux, ~v[0], "aux level");
    end
    DAQ.cal({1'b0, ID}, 1'b0, 3'h2, 6'h1, 1'b0, 5'h0);
    repeat (800) @(negedge clk);
    cmp_bit(cal_edge, 1'b1, "step not held");
    cmp_bit(cal_edge_matrix, 1'b1, "matrix strobe");
    DAQ.cal({1'b0, ID}, 1'b1, 3'h0, 6'h3, 1'b1, 5'h0);
    repeat (1200) @(negedge clk);
    cmp_bit(cal_edge, 1'b1, "high strobe disturbed");
    cmp_bit(cal_aux, 1'b1, "aux with high strobe");
    $display("Test injection done");
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(negedge clk);
    cmp_bit(cal_edge | cal_aux | cal_edge_matrix, 1'b0, "reset state");
    @(posedge clk);
    reset <= 1'b0;
    repeat (20) @(negedge clk);
    $display("Test second reset done");
    results();
  end
endmodule
